/* File: rtl/backlight_regs.svh */
// Timing constants of the backlight control block.
// Assumes a 200 MHz system clock; times are kept in their own unit.
`ifndef BACKLIGHT_REGS_SVH
`define BACKLIGHT_REGS_SVH

`define CLK_PERIOD_PS 5000
`define SWITCH_PERIOD_NS 1000
`define SWITCH_MAX_DUTY_PCT 95
`define EN_LOW_SHDN_US 2500
`define DIM_LOW_SHDN_US 20000
`define DET_WINDOW_US 1000
`define DET_LOW_US 400
`define SOFT_START_US 5000
`define BRIGHT_CODE_RST 10'h3ff

// Cycles per microsecond; keeps every product inside 32 bits
`define CLKS_PER_US (1000000 / `CLK_PERIOD_PS)
`define SWITCH_PERIOD_CYCLES ((`SWITCH_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define SWITCH_MAX_ON_CYCLES ((`SWITCH_PERIOD_CYCLES * `SWITCH_MAX_DUTY_PCT) / 100)
`define EN_LOW_SHDN_CYCLES (`EN_LOW_SHDN_US * `CLKS_PER_US)
`define DIM_LOW_SHDN_CYCLES (`DIM_LOW_SHDN_US * `CLKS_PER_US)
`define DET_WINDOW_CYCLES (`DET_WINDOW_US * `CLKS_PER_US)
`define DET_LOW_CYCLES (`DET_LOW_US * `CLKS_PER_US)
`define SOFT_START_CYCLES (`SOFT_START_US * `CLKS_PER_US)

`endif

/* File: rtl/backlight_pkg.sv */
// Types shared by the backlight control block.
// Assumes nothing beyond the header of constants.
package backlight_pkg;

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_ONE_WIRE,
    MODE_DUTY
  } dim_mode_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_DETECT,
    ST_RUN
  } power_state_t;

endpackage : backlight_pkg

/* File: rtl/pin_sync3.sv */
// Three-stage synchroniser for asynchronous pins and comparator levels.
// Output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Asynchronous in, stable level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            lvl_reg <= s3_reg;
        end
      end
      assign level_out[i] = lvl_reg;
    end
  endgenerate

endmodule : pin_sync3

`default_nettype wire

/* File: rtl/backlight_ctrl.sv */
// Dimming selection and protection sequencing of a two-string backlight driver.
// Pins and comparator trips are asynchronous; brightness writes come from a
// one-wire decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "backlight_regs.svh"

module backlight_ctrl #(
  parameter int CW = 23,
  parameter logic [CW-1:0] EN_SHDN_CYCLES = CW'(`EN_LOW_SHDN_CYCLES),
  parameter logic [CW-1:0] DIM_SHDN_CYCLES = CW'(`DIM_LOW_SHDN_CYCLES),
  parameter logic [CW-1:0] DET_WINDOW_CYCLES = CW'(`DET_WINDOW_CYCLES),
  parameter logic [CW-1:0] DET_LOW_CYCLES = CW'(`DET_LOW_CYCLES),
  parameter logic [CW-1:0] SOFT_START_CYCLES = CW'(`SOFT_START_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host pins
  input wire logic en_pin,
  input wire logic dim_pin,
  // Analog comparator trips
  input wire logic switch_current_limit,
  input wire logic over_temp_hot,
  input wire logic over_temp_cool,
  input wire logic output_overvoltage_guard,
  // Brightness write from one-wire decoder
  input wire logic code_wr,
  input wire logic [9:0] code_wr_data,
  // Power stage controls
  output logic boost_switch_on,
  output logic boost_enable,
  output logic sinks_on,
  output logic [9:0] brightness_code,
  output logic soft_start,
  // Status
  output var backlight_pkg::dim_mode_t dim_mode,
  output var backlight_pkg::power_state_t power_state,
  output logic thermal_shutdown,
  output logic ovp_latched
);
  import backlight_pkg::*;

  localparam logic [7:0] SW_LAST = 8'(`SWITCH_PERIOD_CYCLES - 1);
  localparam logic [7:0] SW_MAX_ON = 8'(`SWITCH_MAX_ON_CYCLES);

  // Synchronised inputs
  logic [5:0] sync_lvl;
  logic en_s;
  logic dim_s;
  logic ilim_s;
  logic hot_s;
  logic cool_s;
  logic ovp_s;

  pin_sync3 #(
    .WIDTH(6)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({output_overvoltage_guard, over_temp_cool, over_temp_hot,
               switch_current_limit, dim_pin, en_pin}),
    .level_out(sync_lvl)
  );

  assign en_s = sync_lvl[0];
  assign dim_s = sync_lvl[1];
  assign ilim_s = sync_lvl[2];
  assign hot_s = sync_lvl[3];
  assign cool_s = sync_lvl[4];
  assign ovp_s = sync_lvl[5];

  // Registers
  power_state_t state_reg;
  power_state_t state_next;
  dim_mode_t mode_reg;
  dim_mode_t mode_next;
  logic en_d_reg;
  logic dim_d_reg;
  logic ovp_d_reg;
  logic [CW-1:0] en_low_cnt_reg;
  logic [CW-1:0] dim_low_cnt_reg;
  logic [CW-1:0] win_cnt_reg;
  logic [CW-1:0] det_low_cnt_reg;
  logic [CW-1:0] ss_cnt_reg;
  logic [7:0] sw_cnt_reg;
  logic [1:0] ovp_cnt_reg;
  logic [1:0] ovp_cnt_next;
  logic ovp_latch_reg;
  logic therm_reg;
  logic sw_on_reg;
  logic sw_on_next;
  logic boost_en_reg;
  logic sinks_reg;
  logic ss_reg;
  logic [9:0] code_reg;

  // Edge and level decode
  wire en_rise = en_s & ~en_d_reg;
  wire dim_rise = dim_s & ~dim_d_reg;
  wire ovp_event = ovp_s & ~ovp_d_reg;
  wire en_off = ~en_s & (en_low_cnt_reg >= EN_SHDN_CYCLES);
  wire dim_off = ~dim_s & (dim_low_cnt_reg >= DIM_SHDN_CYCLES);
  wire pins_off = en_off | dim_off;
  wire wake = (state_reg == ST_OFF) & en_s & dim_s;
  wire det_hit = ~en_s & (det_low_cnt_reg >= DET_LOW_CYCLES);
  wire win_done = win_cnt_reg >= DET_WINDOW_CYCLES;
  wire latch_release = en_rise | dim_rise;
  wire ovp_set = ovp_event & (ovp_cnt_reg != 2'h0);
  wire therm_clear = therm_reg & cool_s & ~hot_s;
  wire ss_start = wake | therm_clear;
  wire powered = (state_reg != ST_OFF) & ~pins_off;
  wire allow = powered & ~hot_s & ~therm_reg & ~ovp_latch_reg & ~ovp_set;
  wire cycle_start = sw_cnt_reg == 8'h00;
  wire duty_gate = (mode_reg == MODE_DUTY) ? dim_s : 1'b1;

  // Power and mode sequencing
  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    unique case (state_reg)
      ST_OFF:
      begin
        mode_next = MODE_NONE;
        if (wake)
          state_next = ST_DETECT;
      end
      ST_DETECT:
      begin
        if (pins_off)
          state_next = ST_OFF;
        else if (det_hit)
        begin
          state_next = ST_RUN;
          mode_next = MODE_ONE_WIRE;
        end
        else if (win_done)
        begin
          state_next = ST_RUN;
          mode_next = MODE_DUTY;
        end
      end
      ST_RUN:
      begin
        if (pins_off)
        begin
          state_next = ST_OFF;
          mode_next = MODE_NONE;
        end
      end
    endcase
  end

  // Over-voltage event count; an event alongside a release still counts
  always_comb
  begin
    ovp_cnt_next = ovp_cnt_reg;
    if (latch_release)
      ovp_cnt_next = {1'b0, ovp_event};
    else if (ovp_event && ovp_cnt_reg != 2'h2)
      ovp_cnt_next = ovp_cnt_reg + 2'h1;
  end

  // Switch gate: on at cycle start, off at limit or maximum duty
  always_comb
  begin
    sw_on_next = sw_on_reg;
    if (!allow || ilim_s)
      sw_on_next = 1'b0;
    else if (cycle_start)
      sw_on_next = 1'b1;
    else if (sw_cnt_reg == SW_MAX_ON)
      sw_on_next = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_OFF;
      mode_reg <= MODE_NONE;
      en_d_reg <= 1'b0;
      dim_d_reg <= 1'b0;
      ovp_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      en_d_reg <= en_s;
      dim_d_reg <= dim_s;
      ovp_d_reg <= ovp_s;
    end
  end

  // Low-time and window counters
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_low_cnt_reg <= '0;
      dim_low_cnt_reg <= '0;
      win_cnt_reg <= '0;
      det_low_cnt_reg <= '0;
    end
    else
    begin
      en_low_cnt_reg <= en_s ? '0 : (en_off ? en_low_cnt_reg : en_low_cnt_reg + 1'b1);
      dim_low_cnt_reg <= dim_s ? '0 : (dim_off ? dim_low_cnt_reg : dim_low_cnt_reg + 1'b1);
      win_cnt_reg <= (state_reg == ST_DETECT) ? win_cnt_reg + 1'b1 : '0;
      det_low_cnt_reg <= (state_reg == ST_DETECT && !en_s) ? det_low_cnt_reg + 1'b1 : '0;
    end
  end

  // Protection latches; a set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovp_cnt_reg <= 2'h0;
      ovp_latch_reg <= 1'b0;
      therm_reg <= 1'b0;
    end
    else
    begin
      ovp_cnt_reg <= ovp_cnt_next;
      if (ovp_set)
        ovp_latch_reg <= 1'b1;
      else if (latch_release)
        ovp_latch_reg <= 1'b0;
      if (hot_s)
        therm_reg <= 1'b1;
      else if (cool_s)
        therm_reg <= 1'b0;
    end
  end

  // Switching cycle, soft-start and outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_cnt_reg <= 8'h00;
      sw_on_reg <= 1'b0;
      boost_en_reg <= 1'b0;
      sinks_reg <= 1'b0;
      ss_cnt_reg <= '0;
      ss_reg <= 1'b0;
    end
    else
    begin
      sw_cnt_reg <= (sw_cnt_reg == SW_LAST) ? 8'h00 : sw_cnt_reg + 8'h01;
      sw_on_reg <= sw_on_next;
      boost_en_reg <= allow;
      sinks_reg <= allow & duty_gate;
      if (ss_start)
        ss_cnt_reg <= SOFT_START_CYCLES;
      else if (ss_cnt_reg != '0)
        ss_cnt_reg <= ss_cnt_reg - 1'b1;
      ss_reg <= ss_start | (ss_cnt_reg > 1);
    end
  end

  // Brightness code, accepted only in one-wire mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      code_reg <= `BRIGHT_CODE_RST;
    else if (code_wr && mode_reg == MODE_ONE_WIRE)
      code_reg <= code_wr_data;
  end

  assign boost_switch_on = sw_on_reg;
  assign boost_enable = boost_en_reg;
  assign sinks_on = sinks_reg;
  assign brightness_code = code_reg;
  assign soft_start = ss_reg;
  assign dim_mode = mode_reg;
  assign power_state = state_reg;
  assign thermal_shutdown = therm_reg;
  assign ovp_latched = ovp_latch_reg;

endmodule : backlight_ctrl

`default_nettype wire

/* File: sim/backlight_ctrl_asserts.sv */
// Port assertions for the backlight control block.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module backlight_ctrl_asserts
  import backlight_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs watched
  input wire logic switch_current_limit,
  input wire logic code_wr,
  input wire logic [9:0] code_wr_data,
  // Outputs watched
  input wire logic boost_switch_on,
  input wire logic boost_enable,
  input wire logic sinks_on,
  input wire logic [9:0] brightness_code,
  input wire logic soft_start,
  input wire backlight_pkg::dim_mode_t dim_mode,
  input wire backlight_pkg::power_state_t power_state,
  input wire logic thermal_shutdown,
  input wire logic ovp_latched
);
  logic [7:0] on_cnt_reg;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      on_cnt_reg <= 8'h00;
    else
      on_cnt_reg <= boost_switch_on ? on_cnt_reg + 8'h01 : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_ovp_power_off: assert property (ovp_latched |-> !boost_enable && !sinks_on)
    else $error("power on while latched");
  a_thermal_off: assert property (thermal_shutdown |=> !boost_enable && !sinks_on)
    else $error("power on while hot");
  a_limit_gate_off: assert property (switch_current_limit [*7] |-> !boost_switch_on)
    else $error("gate on at limit");
  a_gate_max_on: assert property (on_cnt_reg <= 8'hbe)
    else $error("gate on too long");
  a_reset_values: assert property ($rose(arst_n) |-> brightness_code == 10'h3ff
    && power_state == ST_OFF && dim_mode == MODE_NONE)
    else $error("bad reset values");
  a_code_store: assert property (code_wr && dim_mode == MODE_ONE_WIRE
    |=> brightness_code == $past(code_wr_data))
    else $error("code not stored");
  a_code_refused: assert property (code_wr && dim_mode != MODE_ONE_WIRE
    |=> $stable(brightness_code))
    else $error("code taken outside one-wire");
  a_off_no_mode: assert property (power_state == ST_OFF |-> dim_mode == MODE_NONE)
    else $error("mode kept while off");
  a_thermal_restart: assert property ($fell(thermal_shutdown) |-> ##[0:1] soft_start)
    else $error("no soft start after cooling");
endmodule : backlight_ctrl_asserts
bind backlight_ctrl backlight_ctrl_asserts u_chk (.clk, .arst_n, .switch_current_limit,
  .code_wr, .code_wr_data, .boost_switch_on, .boost_enable, .sinks_on, .brightness_code,
  .soft_start, .dim_mode, .power_state, .thermal_shutdown, .ovp_latched);
`default_nettype wire

/* File: sim/host_pins_model.sv */
// Host model driving the enable and dimming pins.
// Assumes callers enter its tasks at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic en_pin,
  output logic dim_pin
);
  initial
  begin
    en_pin = 1'b0;
    dim_pin = 1'b0;
  end
  task automatic set(input logic en, input logic dim, input int n);
    en_pin = en;
    dim_pin = dim;
    repeat (n) @(negedge clk);
  endtask : set
  task automatic start_duty();
    set(1'b1, 1'b1, 60);
  endtask : start_duty
  task automatic start_one_wire();
    set(1'b1, 1'b1, 12);
    set(1'b0, 1'b1, 16);
    set(1'b1, 1'b1, 40);
  endtask : start_one_wire
  // Duty-cycle dimming, period scaled like the bench's shutdown widths
  task automatic dim_pwm(input int low_n, input int high_n, input int periods);
    repeat (periods)
    begin
      set(1'b1, 1'b0, low_n);
      set(1'b1, 1'b1, high_n);
    end
  endtask : dim_pwm
endmodule : host_pins_model
`default_nettype wire

/* File: sim/backlight_ctrl_tb.sv */
// Self-checking bench of the backlight control block.
// Assumes shortened timing parameters and the host pin model.
`timescale 1ns/1ps
`default_nettype none
module backlight_ctrl_tb;
  import backlight_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic switch_current_limit = 1'b0;
  logic over_temp_hot = 1'b0;
  logic over_temp_cool = 1'b0;
  logic output_overvoltage_guard = 1'b0;
  logic code_wr = 1'b0;
  logic [9:0] code_wr_data = 10'h000;
  logic [9:0] last_code;
  wire logic en_pin;
  wire logic dim_pin;
  logic boost_switch_on, boost_enable, sinks_on, soft_start, thermal_shutdown, ovp_latched;
  logic [9:0] brightness_code;
  dim_mode_t dim_mode;
  power_state_t power_state;
  int num_errors = 0;
  int comparisons = 0;
  logic [8:0] flag_q[$];
  logic [9:0] code_q[$];
  logic gate_q[$];
  event flag_ev;
  event code_ev;
  event gate_ev;
  always #2.5 clk = ~clk;
  host_pins_model host (.clk, .en_pin, .dim_pin);
  backlight_ctrl #(.EN_SHDN_CYCLES(23'h32), .DIM_SHDN_CYCLES(23'h50),
    .DET_WINDOW_CYCLES(23'h28), .DET_LOW_CYCLES(23'h0a), .SOFT_START_CYCLES(23'h14)) dut (
    .clk, .arst_n, .en_pin, .dim_pin, .switch_current_limit, .over_temp_hot, .over_temp_cool,
    .output_overvoltage_guard, .code_wr, .code_wr_data, .boost_switch_on, .boost_enable,
    .sinks_on, .brightness_code, .soft_start, .dim_mode, .power_state, .thermal_shutdown,
    .ovp_latched);
  task automatic cmp_flags(input logic [8:0] e);
    logic [8:0] g;
    g = {power_state, dim_mode, boost_enable, sinks_on, soft_start, thermal_shutdown, ovp_latched};
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL flags exp %h got %h", e, g);
    end
  endtask : cmp_flags
  task automatic cmp_code(input logic [9:0] e);
    comparisons++;
    if (brightness_code !== e)
    begin
      num_errors++;
      $display("FAIL code exp %h got %h", e, brightness_code);
    end
  endtask : cmp_code
  task automatic cmp_gate(input logic e);
    comparisons++;
    if (boost_switch_on !== e)
    begin
      num_errors++;
      $display("FAIL gate exp %h got %h", e, boost_switch_on);
    end
  endtask : cmp_gate
  always @(flag_ev) cmp_flags(flag_q.pop_front());
  always @(code_ev) cmp_code(code_q.pop_front());
  always @(gate_ev) cmp_gate(gate_q.pop_front());
  task automatic note_f(input power_state_t s, input dim_mode_t m, input logic [4:0] f);
    flag_q.push_back({s, m, f});
    -> flag_ev;
  endtask : note_f
  task automatic note_c(input logic [9:0] c);
    code_q.push_back(c);
    -> code_ev;
  endtask : note_c
  task automatic note_g(input logic g);
    gate_q.push_back(g);
    -> gate_ev;
  endtask : note_g
  // Back-to-back writes, strobe held high between them
  task automatic write_codes(input int n);
    code_wr = 1'b1;
    repeat (n)
    begin
      code_wr_data = 10'($urandom);
      last_code = code_wr_data;
      @(negedge clk);
    end
    code_wr = 1'b0;
  endtask : write_codes
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic ov_event();
    output_overvoltage_guard = 1'b1;
    wait_n(6);
    output_overvoltage_guard = 1'b0;
    wait_n(6);
  endtask : ov_event
  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(1455));
    wait_n(3);
    arst_n = 1'b1;
    note_f(ST_OFF, MODE_NONE, 5'h00);
    note_c(10'h3ff);
    host.start_duty();
    note_f(ST_RUN, MODE_DUTY, 5'h18);
    host.set(1'b1, 1'b0, 8);
    note_f(ST_RUN, MODE_DUTY, 5'h10);
    write_codes(1);
    note_c(10'h3ff);
    host.set(1'b1, 1'b0, 60);
    note_f(ST_RUN, MODE_DUTY, 5'h10);
    wait_n(30);
    note_f(ST_OFF, MODE_NONE, 5'h00);
    host.start_one_wire();
    note_f(ST_RUN, MODE_ONE_WIRE, 5'h18);
    write_codes(3);
    note_c(last_code);
    host.set(1'b0, 1'b1, 30);
    note_f(ST_RUN, MODE_ONE_WIRE, 5'h18);
    wait_n(40);
    note_f(ST_OFF, MODE_NONE, 5'h00);
    host.start_duty();
    for (int p = 0; p < 2; p++)
    begin
      ov_event();
      note_f(ST_RUN, MODE_DUTY, 5'h18);
      ov_event();
      note_f(ST_RUN, MODE_DUTY, 5'h01);
      host.set(p == 1, p == 0, 4);
      host.set(1'b1, 1'b1, 12);
      note_f(ST_RUN, MODE_DUTY, 5'h18);
    end
    over_temp_hot = 1'b1;
    wait_n(8);
    note_f(ST_RUN, MODE_DUTY, 5'h02);
    over_temp_hot = 1'b0;
    over_temp_cool = 1'b1;
    wait_n(10);
    note_f(ST_RUN, MODE_DUTY, 5'h1c);
    over_temp_cool = 1'b0;
    wait_n(30);
    note_f(ST_RUN, MODE_DUTY, 5'h18);
    host.dim_pwm(8, 12, 6);
    note_f(ST_RUN, MODE_DUTY, 5'h18);
    repeat (40)
    begin
      switch_current_limit = 1'($urandom);
      wait_n($urandom_range(12, 1));
    end
    switch_current_limit = 1'b1;
    wait_n(20);
    note_g(1'b0);
    switch_current_limit = 1'b0;
    for (int k = 0; k < 210 && !boost_switch_on; k++)
      wait_n(1);
    note_g(1'b1);
    wait_n(5);
    give_verdict();
  end
endmodule : backlight_ctrl_tb
`default_nettype wire
